// >>> hdl/external_memory_bus_control.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - release bit clear dedicates pins to bus
// - release bit set: ports, bus overrides accesses
// - release bit resets to zero
// - wait field adds three minus code cycles
// - word mode outputs full word, high strobe
// - byte select copies byte, high strobe, byte select
// - byte write copies byte, high or low strobe
// - write mode ignored on eight-bit bus
// - control register ignores writes when bus off
// - data width bit set selects sixteen bits
// - widths fixed, not software changeable
// - address width frees unused high lines
// - sixteen-bit addressing frees lines nineteen to sixteen
// - address and data share multiplexed lines
// - twenty lines, low sixteen carry data
// - twenty-eight pins including eight control pins
// - waits only when wait enable set
// - wait follows the table instruction cycle
// - idle owned bus: tri-state, strobes high
// - release deferred until executing internally
module external_memory_bus_control
  import ext_bus_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ext_bus_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [7:0] tableLatch,
  output logic rspValid,
  output logic [ext_bus_pkg::AD_W-1:0] rspData,
  input wire logic runningExternal,
  input wire logic dataWidthSelect,
  input wire logic [1:0] addressWidthSelect,
  input wire logic waitEnable,
  input wire logic [ext_bus_pkg::NPINS-1:0] portOut,
  input wire logic [ext_bus_pkg::NPINS-1:0] portOe,
  input wire logic [ext_bus_pkg::NPINS-1:0] pinIn,
  output logic [ext_bus_pkg::NPINS-1:0] pinOut,
  output logic [ext_bus_pkg::NPINS-1:0] pinOe
);
  import ext_bus_pkg::*;

  pin_if pins ();

  // ------------------------------------------------------------
  // fixed configuration
  // ------------------------------------------------------------
  logic wide_q;
  logic [1:0] abw_q;
  logic waitEn_q;

  // straps are caught while reset is held and never again
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wide_q <= dataWidthSelect; // set selects 16-bit data
      abw_q <= addressWidthSelect;
      waitEn_q <= waitEnable;
    end
  end

  logic extMode;
  logic [ADDR_W-1:0] addrMask;
  logic [AD_W-1:0] dataMask;
  assign extMode = (abw_q != ABW_OFF);
  assign addrMask = lineMask(abw_q);
  // a 12-bit address width drops the upper data nibble
  assign dataMask = addrMask[AD_W-1:0] & (wide_q ? '1 : MASK_DATA8);

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic releaseEff_q;
  logic ctrlWr;
  logic statRd;
  logic ctrlRd;
  logic [1:0] waitField;
  logic [1:0] wmField;
  logic owned;
  bus_state_e state_q;

  // bus-off mode locks the register
  assign ctrlWr = regWr && (regAddr == REG_BUS_CONTROL) && extMode;
  assign ctrlRd = regRd && (regAddr == REG_BUS_CONTROL);
  assign statRd = regRd && (regAddr == REG_BUS_STATUS);
  assign waitField = ctrl_q[WAIT_LSB +: 2];
  assign wmField = ctrl_q[WM_LSB +: 2];

  // unimplemented bits never store
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_q <= CTRL_RESET; // bus enabled after reset
    else if (ctrlWr)
      ctrl_q <= regWdata & CTRL_WR_MASK;
  end

  // a release written from external code waits for internal execution
  always_ff @(posedge mclk)
  begin
    if (rst)
      releaseEff_q <= 1'b0;
    else if (!runningExternal)
      releaseEff_q <= ctrl_q[REL_BIT];
  end

  logic [7:0] statusWord;
  logic [7:0] regRdata_q;
  assign statusWord = {5'h00, owned, releaseEff_q, (state_q != ST_IDLE)};

  // read data stand only in the cycle after the strobe; unmapped read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      regRdata_q <= 8'h00;
    else
      regRdata_q <= ctrlRd ? ctrl_q : (statRd ? statusWord : 8'h00);
  end
  assign regRdata = regRdata_q;

  // ------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------
  logic phaseLast;
  logic timerLoad;
  count_t timerVal;
  count_t waitCnt;
  logic [ADDR_W-1:0] addr_q;
  logic write_q;
  logic [BYTE_W-1:0] data_q;
  logic [BYTE_W-1:0] lowHeld_q;
  logic take;
  logic wordMode;
  logic holdOnly;
  logic strobeEnd;
  logic rspValid_q;
  logic [AD_W-1:0] rspData_q;
  bus_state_e state_d;

  // waits count only when enabled; code 11 adds none
  assign waitCnt = waitEn_q ? count_t'(WAIT_NONE - waitField) * TCY_CNT : '0;
  assign wordMode = wide_q && wmField[WM_WORD_BIT];
  assign reqReady = (state_q == ST_IDLE) && extMode;
  assign take = reqValid && reqReady;
  // word mode parks an even byte until its odd partner arrives
  assign holdOnly = take && reqWrite && wordMode && !reqAddr[0];
  assign strobeEnd = phaseLast &&
    (((state_q == ST_DATA) && (waitCnt == '0)) || (state_q == ST_WAIT));

  // next state and the length of the phase being entered
  always_comb
  begin
    state_d = state_q;
    timerLoad = 1'b0;
    timerVal = '0;
    unique case (state_q)
      ST_IDLE:
        if (take && !holdOnly)
        begin
          state_d = ST_ADDR;
          timerLoad = 1'b1;
          timerVal = ALE_CNT;
        end
      ST_ADDR:
        if (phaseLast)
        begin
          state_d = ST_DATA;
          timerLoad = 1'b1;
          timerVal = STROBE_CNT;
        end
      ST_DATA:
        if (phaseLast)
        begin
          // the wait follows the instruction cycle
          state_d = (waitCnt != '0) ? ST_WAIT : ST_IDLE;
          timerLoad = (waitCnt != '0);
          timerVal = waitCnt;
        end
      ST_WAIT:
        if (phaseLast)
          state_d = ST_IDLE;
    endcase
  end

  phase_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .load(timerLoad),
    .loadVal(timerVal),
    .last(phaseLast)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // request capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      addr_q <= '0;
      write_q <= 1'b0;
      data_q <= '0;
      lowHeld_q <= '0;
    end
    else if (take)
    begin
      addr_q <= reqAddr;
      write_q <= reqWrite;
      data_q <= tableLatch;
      if (holdOnly)
        lowHeld_q <= tableLatch;
    end
  end

  // answer pulse at the end of the strobe, or right after a parked byte is taken; read word sampled at the strobe end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rspValid_q <= 1'b0;
      rspData_q <= '0;
    end
    else
    begin
      rspValid_q <= holdOnly || strobeEnd;
      if (strobeEnd && !write_q)
        rspData_q <= pinIn[AD_W-1:0] & dataMask;
    end
  end
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;

  // ------------------------------------------------------------
  // pin values
  // ------------------------------------------------------------
  logic active;
  logic strobing;
  logic wrLow;
  logic wrHigh;
  logic selLow;
  logic selHigh;
  logic byteSel;
  logic [AD_W-1:0] wrWord;
  logic [AD_W-1:0] adOut;
  logic [AD_W-1:0] adOe;
  logic [CTRL_W-1:0] ctrlOut;

  assign active = (state_q != ST_IDLE);
  assign strobing = (state_q == ST_DATA) || (state_q == ST_WAIT);
  assign byteSel = wide_q && (wmField == WM_BYTE_SELECT);
  // word mode sends the full word, other modes copy the byte
  assign wrWord = wordMode ? {data_q, lowHeld_q} : {data_q, data_q};
  // strobe choice per mode; narrow bus always uses the low strobe
  assign wrHigh = strobing && write_q && wide_q && (wordMode || byteSel || addr_q[0]);
  assign wrLow = strobing && write_q && (!wide_q || (!wordMode && !byteSel && !addr_q[0]));
  assign selHigh = strobing && write_q && byteSel && addr_q[0];
  assign selLow = strobing && write_q && byteSel && !addr_q[0];

  // address then data on the same lines
  assign adOut = (state_q == ST_ADDR) ? addr_q[AD_W-1:0] : wrWord;
  assign adOe = (state_q == ST_ADDR) ? addrMask[AD_W-1:0] :
    ((strobing && write_q) ? dataMask : '0); // idle lines float

  // active-low strobes idle high, latch and byte address idle low
  always_comb
  begin
    ctrlOut = '0;
    ctrlOut[C_ALE] = (state_q == ST_ADDR);
    ctrlOut[C_OE] = !(strobing && !write_q);
    ctrlOut[C_WRL] = !wrLow;
    ctrlOut[C_WRH] = !wrHigh;
    ctrlOut[C_BA0] = active && addr_q[0];
    ctrlOut[C_CE] = !active;
    ctrlOut[C_LB] = !selLow;
    ctrlOut[C_UB] = !selHigh;
  end

  // claim: dedicated while not released, else only during a cycle
  assign owned = extMode && (active || !releaseEff_q);
  // lines beyond the address width stay with the ports
  assign pins.busOwn = {{CTRL_W{owned}}, addrMask & {ADDR_W{owned}}};
  assign pins.busOut = {ctrlOut, addr_q[ADDR_W-1:AD_W], adOut};
  assign pins.busOe = {{CTRL_W{1'b1}},
    addrMask[ADDR_W-1:AD_W] & {(ADDR_W - AD_W){active}}, adOe};

  pin_mux u_mux (
    .bus(pins),
    .portOut(portOut),
    .portOe(portOe),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  count_t waitSeen_q;
  // helper: cycles spent in the wait phase so far
  always_ff @(posedge mclk)
  begin
    if (rst || state_q != ST_WAIT)
      waitSeen_q <= '0;
    else
      waitSeen_q <= waitSeen_q + count_t'(1);
  end

  chk_dedicated_pins: assert property (
    extMode && !releaseEff_q |-> &pins.busOwn[NPINS-1:CTRL_LSB])
    else $error("bus pins not dedicated while not released");
  chk_released_ports: assert property (
    releaseEff_q && state_q == ST_IDLE |-> pins.busOwn == '0 && pinOe == portOe)
    else $error("released bus still holds pins while idle");
  chk_reset_release: assert property (
    $past(rst) |-> ctrl_q == CTRL_RESET && !releaseEff_q)
    else $error("control register not cleared by reset");
  chk_wait_length: assert property (
    state_q == ST_WAIT && phaseLast |-> waitSeen_q + count_t'(1) == waitCnt)
    else $error("wait phase length differs from wait field");
  chk_word_write: assert property (
    strobing && write_q && wordMode |->
      !pinOut[CTRL_LSB + C_WRH] && pinOut[CTRL_LSB + C_WRL] &&
      pinOut[AD_W-1:BYTE_W] == data_q && pinOut[BYTE_W-1:0] == lowHeld_q)
    else $error("word write not driven as full word on high strobe");
  chk_byte_select: assert property (
    strobing && write_q && byteSel |->
      !pinOut[CTRL_LSB + C_WRH] &&
      (pinOut[CTRL_LSB + C_UB] != pinOut[CTRL_LSB + C_LB]) &&
      pinOut[AD_W-1:BYTE_W] == pinOut[BYTE_W-1:0])
    else $error("byte select write strobes wrong");
  chk_byte_write: assert property (
    strobing && write_q && wide_q && !wordMode && !byteSel |->
      (pinOut[CTRL_LSB + C_WRH] != pinOut[CTRL_LSB + C_WRL]))
    else $error("byte write must pulse exactly one write strobe");
  chk_narrow_strobe: assert property (
    !wide_q && strobing && write_q |->
      !pinOut[CTRL_LSB + C_WRL] && pinOut[CTRL_LSB + C_WRH])
    else $error("8-bit bus used high strobe");
  chk_locked_reg: assert property (
    !extMode && regWr |=> $stable(ctrl_q))
    else $error("control register written in bus-off mode");
  chk_high_lines: assert property (
    abw_q == ABW_16 |-> pins.busOwn[ADDR_W-1:AD_W] == '0)
    else $error("upper address lines claimed in 16-bit addressing");
  chk_idle_levels: assert property (
    owned && !active |-> adOe == '0 && pinOut[CTRL_LSB + C_CE] &&
      !pinOut[CTRL_LSB + C_ALE] && !pinOut[CTRL_LSB + C_BA0])
    else $error("idle bus levels wrong");
  chk_deferred_release: assert property (
    runningExternal |=> $stable(releaseEff_q))
    else $error("release took effect while running externally");
  chk_reserved_zero: assert property (
    (ctrl_q & ~CTRL_WR_MASK) == 8'h00)
    else $error("unimplemented control bits set");

  cov_word_write: cover property (strobeEnd && write_q && wordMode);
  cov_long_wait: cover property (state_q == ST_WAIT && waitField == 2'h0);
  cov_read_done: cover property (strobeEnd && !write_q);
  cov_handover: cover property ($rose(releaseEff_q));
endmodule
`default_nettype wire

// >>> hdl/ext_bus_pkg.sv
package ext_bus_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int TCY_NS = 40;
  localparam int ALE_NS = 10;
  localparam int TCY_CLKS = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ALE_CLKS = (ALE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;
  typedef logic [CNT_W-1:0] count_t;
  localparam count_t ALE_CNT = count_t'(ALE_CLKS);
  localparam count_t STROBE_CNT = count_t'(TCY_CLKS - ALE_CLKS);
  localparam count_t TCY_CNT = count_t'(TCY_CLKS);
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam logic [REG_ADDR_W-1:0] REG_BUS_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_BUS_STATUS = 4'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'hb3;
  localparam int REL_BIT = 7;
  localparam int WAIT_LSB = 4;
  localparam int WM_LSB = 0;
  localparam int WM_WORD_BIT = 1;
  localparam logic [1:0] WM_BYTE_SELECT = 2'h1;
  localparam logic [1:0] WAIT_NONE = 2'h3;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_RELEASED_BIT = 1;
  localparam int ST_OWNED_BIT = 2;
  // ------------------------------------------------------------
  // address width codes and pin layout
  // ------------------------------------------------------------
  localparam logic [1:0] ABW_20 = 2'h0;
  localparam logic [1:0] ABW_16 = 2'h1;
  localparam logic [1:0] ABW_12 = 2'h2;
  localparam logic [1:0] ABW_OFF = 2'h3;
  localparam int ADDR_W = 20;
  localparam int AD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CTRL_W = 8;
  localparam int NPINS = 28;
  localparam int CTRL_LSB = 20;
  localparam int C_ALE = 0;
  localparam int C_OE = 1;
  localparam int C_WRL = 2;
  localparam int C_WRH = 3;
  localparam int C_BA0 = 4;
  localparam int C_CE = 5;
  localparam int C_LB = 6;
  localparam int C_UB = 7;
  localparam logic [ADDR_W-1:0] MASK_20 = 20'hfffff;
  localparam logic [ADDR_W-1:0] MASK_16 = 20'h0ffff;
  localparam logic [ADDR_W-1:0] MASK_12 = 20'h00fff;
  localparam logic [ADDR_W-1:0] MASK_NONE = 20'h00000;
  localparam logic [AD_W-1:0] MASK_DATA8 = 16'h00ff;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT} bus_state_e;

  // lines that the configured address width hands to the bus
  function automatic logic [ADDR_W-1:0] lineMask(input logic [1:0] abw);
    unique case (abw)
      ABW_20: lineMask = MASK_20;
      ABW_16: lineMask = MASK_16;
      ABW_12: lineMask = MASK_12;
      ABW_OFF: lineMask = MASK_NONE;
    endcase
  endfunction
endpackage

// >>> hdl/pin_if.sv
`timescale 1ns/1ps
`default_nettype none
// per-pin bus claim, value and drive between sequencer and pin mux
interface pin_if;
  logic [ext_bus_pkg::NPINS-1:0] busOwn;
  logic [ext_bus_pkg::NPINS-1:0] busOut;
  logic [ext_bus_pkg::NPINS-1:0] busOe;
  modport ctrl (output busOwn, output busOut, output busOe);
  modport mux (input busOwn, input busOut, input busOe);
endinterface
`default_nettype wire

// >>> hdl/phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module phase_timer
  import ext_bus_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire ext_bus_pkg::count_t loadVal,
  output logic last
);
  count_t cnt_q;
  count_t cnt_d;

  // a phase of N cycles sees N, N-1 .. 1; last marks its final cycle
  assign cnt_d = load ? loadVal : ((cnt_q != '0) ? cnt_q - count_t'(1) : cnt_q);
  assign last = (cnt_q == count_t'(1));

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// >>> hdl/pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mux
  import ext_bus_pkg::*;
(
  pin_if.mux bus,
  input wire logic [ext_bus_pkg::NPINS-1:0] portOut,
  input wire logic [ext_bus_pkg::NPINS-1:0] portOe,
  output logic [ext_bus_pkg::NPINS-1:0] pinOut,
  output logic [ext_bus_pkg::NPINS-1:0] pinOe
);
  // the bus overrides port value and enable on each claimed pin
  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    assign pinOut[i] = bus.busOwn[i] ? bus.busOut[i] : portOut[i];
    assign pinOe[i] = bus.busOwn[i] ? bus.busOe[i] : portOe[i];
  end
endmodule
`default_nettype wire

// >>> testbench/ext_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// external parallel memory behind the multiplexed lines
// ------------------------------------------------------------
module ext_memory_model
#(
  parameter int ACCESS_CLKS = 1
)
(
  input wire logic mclk,
  input wire logic [27:0] pinOut,
  input wire logic [27:0] pinOe,
  output logic [15:0] memBus
);
  logic [19:0] addrQ;
  logic [3:0] oeAge;
  logic oeLow;

  initial memBus = 16'h0000;
  // output enable is active low and counts only while the device drives it
  assign oeLow = pinOe[21] & ~pinOut[21];

  // address taken off the shared lines while the latch pin is high
  always @(posedge mclk)
  begin
    if (pinOe[20] && pinOut[20])
      addrQ <= pinOut[19:0];
    oeAge <= oeLow ? oeAge + 4'h1 : 4'h0;
    // data only after the access time; an idle bus never keeps its last value
    if (oeLow && oeAge >= 4'(ACCESS_CLKS))
      memBus <= addrQ[15:0] ^ 16'hc35a;
    else
      memBus <= ~memBus;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_external_memory_bus_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_bus_control;
  import ext_bus_pkg::*;
  typedef struct packed {logic chk; logic [7:0] lat; logic [15:0] data;} expect_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [REG_ADDR_W-1:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic reqValid = 1'b0;
  logic reqReady;
  logic reqWrite = 1'b0;
  logic [ADDR_W-1:0] reqAddr = 20'h00000;
  logic [7:0] tableLatch = 8'h00;
  logic rspValid;
  logic [AD_W-1:0] rspData;
  logic runningExternal = 1'b0;
  logic dataWidthSelect = 1'b1;
  logic [1:0] addressWidthSelect = ABW_20;
  logic waitEnable = 1'b1;
  logic [NPINS-1:0] portOut = 28'h0;
  logic [NPINS-1:0] portOe = 28'h0;
  logic [NPINS-1:0] pinIn;
  logic [NPINS-1:0] pinOut;
  logic [NPINS-1:0] pinOe;
  logic [15:0] memBus;
  logic [31:0] seed = 32'h814a;
  logic rdSeen = 1'b0;
  logic dw16 = 1'b1;
  int cyc = 0;
  int takeCyc = 0;
  int fails = 0;
  int checksDone = 0;
  logic [7:0] regQ[$];
  expect_s rspQ[$];

  always #5 mclk = ~mclk;
  // wire level: whoever enables drives, else the memory side on lines 15..0 and the inverted output on lines 27..16
  assign pinIn = (pinOe & pinOut) | (~pinOe & {~pinOut[27:16], memBus});

  external_memory_bus_control u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .tableLatch(tableLatch), .rspValid(rspValid), .rspData(rspData),
    .runningExternal(runningExternal), .dataWidthSelect(dataWidthSelect),
    .addressWidthSelect(addressWidthSelect), .waitEnable(waitEnable), .portOut(portOut),
    .portOe(portOe), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  ext_memory_model u_mem (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .memBus(memBus));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] ctl(input logic oe, write_strobe_low, write_strobe_high, ba0, lb, ub);
    return {ub, lb, 1'b0, ba0, write_strobe_high, write_strobe_low, oe, 1'b0};
  endfunction

  task automatic completeRun();
    $display("checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmpVal(input string what, input logic [27:0] exp, input logic [27:0] got);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %0s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic giveUp(input string what);
    fails++;
    $display("wrong value %0s: expected done, seen timeout", what);
    completeRun();
  endtask

  task automatic cmpRsp();
    expect_s e;
    if (rspQ.size() == 0)
    begin
      cmpVal("unexpected response", 28'h0, 28'h1);
      return;
    end
    e = rspQ.pop_front();
    cmpVal("latency", {20'h0, e.lat}, 28'(cyc - takeCyc));
    if (e.chk)
      cmpVal("read word", {12'h0, e.data}, {12'h0, rspData});
  endtask

  task automatic doReset(input logic dw, input logic [1:0] abw, input logic we);
    @(posedge mclk);
    rst <= 1'b1;
    dataWidthSelect <= dw;
    addressWidthSelect <= abw;
    waitEnable <= we;
    runningExternal <= 1'b0;
    seed = xorshift(seed);
    portOut <= seed[27:0];
    seed = xorshift(seed);
    portOe <= seed[27:0];
    dw16 = dw;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    regQ.push_back(exp);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask

  // one bus access; strobes are sampled mid strobe phase
  task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] b,
    input logic [7:0] expLat, input logic [15:0] expAd, input logic [7:0] expCtl);
    expect_s e;
    int n;
    logic [15:0] m;
    logic [7:0] cm;
    m = dw16 ? 16'hffff : 16'h00ff;
    cm = wr ? 8'hff : 8'h3f; // byte selects on reads are left open
    e = '{chk: !wr, lat: expLat, data: (a[15:0] ^ 16'hc35a) & m};
    rspQ.push_back(e);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    tableLatch <= b;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (reqReady !== 1'b1 && n < 20);
    reqValid <= 1'b0;
    if (n >= 20)
      giveUp("ready");
    #1;
    // latency counts from the cycle in which the request stood
    takeCyc = cyc - 1;
    if (expLat != 8'h01)
    begin
      // the cycle right after the take is the address phase
      cmpVal("address phase", {11'h0, 1'b1, a[15:0]},
        {11'h0, pinOut[20], pinOut[15:0]});
      repeat (2) @(posedge mclk);
      #1;
      cmpVal("strobes", {20'h0, expCtl & cm}, {20'h0, pinOut[27:20] & cm});
      cmpVal("data lines", {12'h0, wr ? expAd & m : 16'h0},
        {12'h0, wr ? pinOut[15:0] & m : pinOe[15:0]});
    end
    n = 0;
    while (rspQ.size() > 0 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 300)
      giveUp("response");
  endtask

  // ------------------------------------------------------------
  // result monitor
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rdSeen <= regRd;
  end

  // read data stands one cycle only, so it is zero whenever no read is due
  always @(negedge mclk)
  begin
    if (rdSeen)
      cmpVal("register read", {20'h0, regQ.pop_front()}, {20'h0, regRdata});
    else
      cmpVal("read data idle", 28'h0, {20'h0, regRdata});
    if (rspValid === 1'b1)
      cmpRsp();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] b;
    logic [7:0] park;
    logic [19:0] a;
    park = 8'h00;
    doReset(1'b1, ABW_20, 1'b1);
    regRead(REG_BUS_CONTROL, CTRL_RESET);
    regRead(REG_BUS_STATUS, 8'h04);
    @(negedge mclk);
    cmpVal("idle enables", {8'hff, 20'h0}, pinOe);
    cmpVal("idle strobes", {20'h0, 8'hee}, {20'h0, pinOut[27:20]});
    regWrite(REG_BUS_CONTROL, 8'h7f);
    regRead(REG_BUS_CONTROL, 8'h33);
    regRead(4'hf, 8'h00);
    $display("test register map done");
    // straps moved after reset must not matter
    dataWidthSelect <= 1'b0;
    waitEnable <= 1'b0;
    for (int w = 0; w < 4; w++)
    begin
      regWrite(REG_BUS_CONTROL, {2'b00, w[1:0], 4'h2});
      seed = xorshift(seed);
      access(1'b0, seed[19:0], 8'h00, 8'(5 + (3 - w) * 4), 16'h0,
        ctl(1'b0, 1'b1, 1'b1, seed[0], 1'b1, 1'b1));
    end
    $display("test wait states done");
    for (int m = 0; m < 3; m++)
      for (int p = 0; p < 2; p++)
      begin
        seed = xorshift(seed);
        b = seed[27:20];
        a = {seed[19:1], p[0]};
        regWrite(REG_BUS_CONTROL, 8'h30 | 8'(m));
        if (m == 2 && p == 0)
        begin
          park = b;
          access(1'b1, a, b, 8'h01, 16'h0, 8'h00);
        end
        else
          access(1'b1, a, b, 8'h05, m == 2 ? {b, park} : {b, b},
            m == 2 ? ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1)
            : m == 1 ? ctl(1'b1, 1'b1, 1'b0, p[0], p[0], !p[0])
            : ctl(1'b1, p[0], !p[0], p[0], 1'b1, 1'b1));
      end
    $display("test write modes done");
    doReset(1'b0, ABW_16, 1'b0);
    regWrite(REG_BUS_CONTROL, 8'h02);
    seed = xorshift(seed);
    access(1'b0, seed[19:0], 8'h00, 8'h05, 16'h0,
      ctl(1'b0, 1'b1, 1'b1, seed[0], 1'b1, 1'b1));
    access(1'b1, {seed[19:1], 1'b0}, seed[27:20], 8'h05, {8'h00, seed[27:20]},
      ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
    @(negedge mclk);
    cmpVal("upper lines", {20'h0, portOut[19:16], portOe[19:16]},
      {20'h0, pinOut[19:16], pinOe[19:16]});
    $display("test eight bit bus done");
    doReset(1'b1, ABW_OFF, 1'b1);
    regWrite(REG_BUS_CONTROL, 8'h80);
    regRead(REG_BUS_CONTROL, 8'h00);
    @(negedge mclk);
    cmpVal("port pins", portOut ^ portOe, pinOut ^ pinOe);
    cmpVal("ready when off", 28'h0, {27'h0, reqReady});
    $display("test bus off done");
    doReset(1'b1, ABW_20, 1'b1);
    runningExternal <= 1'b1;
    regWrite(REG_BUS_CONTROL, 8'hb2);
    regRead(REG_BUS_STATUS, 8'h04);
    runningExternal <= 1'b0;
    repeat (2) @(posedge mclk);
    regRead(REG_BUS_STATUS, 8'h02);
    @(negedge mclk);
    cmpVal("released pins", portOut ^ portOe, pinOut ^ pinOe);
    seed = xorshift(seed);
    access(1'b0, seed[19:0], 8'h00, 8'h05, 16'h0,
      ctl(1'b0, 1'b1, 1'b1, seed[0], 1'b1, 1'b1));
    regRead(REG_BUS_CONTROL, 8'hb2);
    $display("test bus release done");
    completeRun();
  end
endmodule
`default_nettype wire
